// ==== verif/psled_board.sv ====
// Board model: strap resistors and LEDs on the shared pins
`timescale 1ns/1ps
module psled_board #(
    parameter logic [4:0] strap_value = 5'h15
) (
    // Device side of the shared pins
    input wire logic [4:0] led_level,
    input wire logic [4:0] drive_enable,
    // Level seen back at the pins
    output logic [4:0] pin_level
);
    // No pulls inside the part, so only the board resistor sets an undriven pin
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_level[i] = drive_enable[i] ? led_level[i] : strap_value[i];
        end
    end
endmodule

// ==== verif/psled_driver_properties.sv ====
// Port assertions of the PHY status LED driver
`timescale 1ns/1ps
module psled_driver_checker (
    // Clock and reset
    input wire logic clock, input wire logic reset, input wire logic clock_enable,
    // Status inputs and register port
    input wire logic link_up, input wire logic transmit_active, input wire logic receive_active,
    input wire logic reg_read, input wire logic [31:0] reg_read_data,
    // Indicators and pin enables
    input wire logic duplex_indicator, input wire logic collision_indicator,
    input wire logic good_link_indicator, input wire logic transmit_activity_indicator,
    input wire logic receive_activity_indicator, input wire logic [4:0] strap_pin_enable,
    input wire logic link_speed_indicator, input wire logic media_speed_100
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Last edge ran out of reset, so one-cycle lags are meaningful
    sequence s_live; !$past(reset) && $past(clock_enable); endsequence
    sequence s_release; $fell(reset) ##0 clock_enable[*3]; endsequence
    property p_link; s_live |-> good_link_indicator == $past(link_up); endproperty
    a_link: assert property (p_link) else $error("link LED lag wrong");
    property p_tx; s_live |-> transmit_activity_indicator == $past(transmit_active); endproperty
    a_tx: assert property (p_tx) else $error("transmit LED lag wrong");
    property p_rx; s_live |-> receive_activity_indicator == $past(receive_active); endproperty
    a_rx: assert property (p_rx) else $error("receive LED lag wrong");
    property p_speed; s_live |-> link_speed_indicator == media_speed_100; endproperty
    a_speed: assert property (p_speed) else $error("speed LED not from mode");
    property p_col; duplex_indicator |-> !collision_indicator; endproperty
    a_col: assert property (p_col) else $error("collision shown in full duplex");
    property p_read; s_live ##0 !$past(reg_read) |-> reg_read_data == 32'h00000000; endproperty
    a_read: assert property (p_read) else $error("read data outside its cycle");
    property p_held; disable iff (1'b0) reset |-> strap_pin_enable == 5'h00; endproperty
    a_held: assert property (p_held) else $error("pins driven in reset");
    property p_capture; s_release |=> strap_pin_enable == 5'h1F; endproperty
    a_capture: assert property (p_capture) else $error("pins not switched to LEDs");
endmodule
bind psled_driver psled_driver_checker u_chk (.clock, .reset, .clock_enable, .link_up,
    .transmit_active, .receive_active, .reg_read, .reg_read_data, .duplex_indicator,
    .collision_indicator, .good_link_indicator, .transmit_activity_indicator,
    .receive_activity_indicator, .strap_pin_enable, .link_speed_indicator, .media_speed_100);

// ==== verif/psled_driver_tb_top.sv ====
// Self-checking bench of the PHY status LED driver
`timescale 1ns/1ps
module psled_driver_tb_top;
    logic clock = 1'b0, reset = 1'b1, clock_enable = 1'b1, link_up = 1'b0, autoneg_done = 1'b1;
    logic autoneg_speed_100 = 1'b0, autoneg_full_duplex = 1'b1, collision_seen = 1'b1;
    logic transmit_active = 1'b0, receive_active = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_address = 8'h00;
    logic [31:0] reg_write_data = 32'h00000000, reg_read_data, seen;
    logic [4:0] phy_address_strap, strap_pin_enable;
    logic duplex_indicator, collision_indicator, good_link_indicator, transmit_activity_indicator;
    logic receive_activity_indicator, link_speed_indicator, media_speed_100;
    logic [31:0] cfg [3] = '{32'h00000005, 32'h00000003, 32'h00000000};
    logic [3:0] want [3] = '{4'b0010, 4'b1101, 4'b0010};
    int errors = 0, tests_run = 0;
    always #10 clock = ~clock;
    psled_driver dut (.clock, .reset, .clock_enable, .link_up, .autoneg_done, .autoneg_speed_100,
        .autoneg_full_duplex, .collision_seen, .transmit_active, .receive_active, .reg_address,
        .reg_write_data, .reg_write, .reg_read, .reg_read_data, .phy_address_strap, .duplex_indicator,
        .collision_indicator, .good_link_indicator, .transmit_activity_indicator,
        .receive_activity_indicator, .strap_pin_enable, .link_speed_indicator, .media_speed_100);
    psled_board board (.led_level({receive_activity_indicator, transmit_activity_indicator,
        good_link_indicator, collision_indicator, duplex_indicator}),
        .drive_enable(strap_pin_enable), .pin_level(phy_address_strap));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes; read data is taken in the cycle after the strobe only
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_address <= a;
        reg_write_data <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clock);
        reg_address <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 seen = reg_read_data;
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clock);
        #1 check(strap_pin_enable, 5'h00);
        @(posedge clock);
        reset <= 1'b0;
        repeat (6) @(posedge clock);
        #1 check(phy_address_strap, 5'h02);
        reg_rd(8'h00);
        check(seen, 32'h00000015);
        reg_wr(8'h00, 32'h0000000A);
        reg_rd(8'h00);
        check(seen, 32'h0000000A);
        reg_rd(8'h0C);
        check(seen, 32'h00000000);
        @(posedge clock);
        link_up <= 1'b1;
        transmit_active <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check({good_link_indicator, transmit_activity_indicator, receive_activity_indicator}, 3'b110);
        @(posedge clock);
        transmit_active <= 1'b0;
        receive_active <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check({transmit_activity_indicator, receive_activity_indicator, phy_address_strap}, 7'h36);
        // Forced 10 full, forced 100 half, then the negotiated 10 full
        for (int i = 0; i < 3; i++) begin
            reg_wr(8'h04, cfg[i]);
            repeat (4) @(posedge clock);
            #1 check({media_speed_100, link_speed_indicator, duplex_indicator, collision_indicator}, want[i]);
        end
        // Clock enable low freezes the LEDs; then mode holds while negotiation is pending
        @(posedge clock);
        clock_enable <= 1'b0;
        transmit_active <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check({transmit_activity_indicator, strap_pin_enable}, 6'h1F);
        @(posedge clock);
        clock_enable <= 1'b1;
        autoneg_done <= 1'b0;
        autoneg_speed_100 <= 1'b1;
        repeat (4) @(posedge clock);
        #1 check({media_speed_100, transmit_activity_indicator}, 2'b01);
        reg_rd(8'h08);
        check(seen, 32'h0000003B);
        give_verdict();
    end
endmodule

// ==== verilog/psled_driver.sv ====
// PHY status LED driver with shared strap capture
`timescale 1ns/1ps
module psled_driver (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // Internal link state, same clock domain
    input wire logic link_up,
    input wire logic autoneg_done,
    input wire logic autoneg_speed_100,
    input wire logic autoneg_full_duplex,
    input wire logic collision_seen,
    input wire logic transmit_active,
    input wire logic receive_active,
    // Register port
    input wire logic [7:0] reg_address,
    input wire logic [31:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_read_data,
    // Shared strap/LED pins: input, output, output enable
    input wire logic [4:0] phy_address_strap,
    output logic duplex_indicator,
    output logic collision_indicator,
    output logic good_link_indicator,
    output logic transmit_activity_indicator,
    output logic receive_activity_indicator,
    output logic [4:0] strap_pin_enable,
    // Dedicated speed LED and media mode
    output logic link_speed_indicator,
    output logic media_speed_100
);
    // Synchronised strap levels and the captured address
    logic [4:0] strap_meta;
    logic [4:0] strap_sync;
    logic [4:0] phy_control_register;
    // Capture sequencing after reset release
    logic [1:0] settle_count;
    logic settle_done;
    logic strap_captured;
    psled_pkg::psled_phase_t phase;
    // Software configuration and decoded write strobes
    logic [31:0] config_reg;
    logic forced_mode;
    logic write_phy_control;
    logic write_config;
    // Resolved operating mode and its next values
    logic speed_100;
    logic full_duplex;
    logic next_speed_100;
    logic next_full_duplex;
    // Register read path
    logic [31:0] status_word;
    logic [31:0] next_read_data;

    // Address match on a strobe; reused by every write decode
    function automatic logic psled_hit(input logic strobe, input logic [7:0] address, input logic [7:0] target);
        psled_hit = strobe && (address == target);
    endfunction

    // Duplex LED term, shared by the LED flop and the status word
    function automatic logic psled_duplex_on(input logic link, input logic full);
        psled_duplex_on = link && full;
    endfunction

    // Collision term: masked in full duplex, where no collision can occur
    function automatic logic psled_collision_on(input logic collision, input logic full);
        psled_collision_on = collision && !full;
    endfunction

    // Each pin passes two flops; the first stage feeds only the second
    // Reset clears both stages, so no stale level can reach the capture
    for (genvar g = 0; g < psled_pkg::strap_width; g++) begin : g_strap_sync
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                strap_meta[g] <= 1'b0;
                strap_sync[g] <= 1'b0;
            end else if (clock_enable) begin
                strap_meta[g] <= phy_address_strap[g];
                strap_sync[g] <= strap_meta[g];
            end
        end
    end

    // Settle counter: both synchroniser stages must hold pin levels first
    // It stops at its end point, so the capture condition below stays true
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            settle_count <= 2'h0;
        end else if (clock_enable && !settle_done) begin
            settle_count <= settle_count + 2'h1;
        end
    end

    // Synchronised straps are settled once the counter reaches its end
    assign settle_done = (settle_count == psled_pkg::strap_settle_cycles);

    // Capture flag: set once, cleared only by reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strap_captured <= 1'b0;
        end else if (clock_enable && settle_done) begin
            strap_captured <= 1'b1;
        end
    end

    // Output phase: pins stay inputs while the board straps are read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase <= psled_pkg::psled_strap_phase;
        end else if (clock_enable && settle_done) begin
            phase <= psled_pkg::psled_led_phase;
        end
    end

    // Address register: strap level once after reset, software writes after that
    // A write that lands on the capture edge loses, so the strap always wins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phy_control_register <= psled_pkg::phy_address_reset;
        end else if (clock_enable) begin
            if (settle_done && !strap_captured) begin
                phy_control_register <= strap_sync;
            end else if (write_phy_control && strap_captured) begin
                phy_control_register <= reg_write_data[4:0];
            end
        end
    end

    // Write strobes decoded once for both writable registers
    assign write_phy_control = psled_hit(reg_write, reg_address, psled_pkg::addr_phy_control);
    assign write_config = psled_hit(reg_write, reg_address, psled_pkg::addr_config);

    // Configuration register: force enable, forced speed, forced duplex
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            config_reg <= psled_pkg::config_reset;
        end else if (clock_enable && write_config) begin
            config_reg <= {29'h0, reg_write_data[2:0]};
        end
    end

    // Forced setting overrides any negotiation outcome
    assign forced_mode = config_reg[psled_pkg::cfg_force_bit];

    // Speed choice: forced setting first, then a finished negotiation, else hold
    always_comb begin
        next_speed_100 = speed_100;
        if (forced_mode) begin
            next_speed_100 = config_reg[psled_pkg::cfg_speed_bit];
        end else if (autoneg_done) begin
            next_speed_100 = autoneg_speed_100;
        end
    end

    // Duplex choice, same priority as the speed choice
    always_comb begin
        next_full_duplex = full_duplex;
        if (forced_mode) begin
            next_full_duplex = config_reg[psled_pkg::cfg_duplex_bit];
        end else if (autoneg_done) begin
            next_full_duplex = autoneg_full_duplex;
        end
    end

    // Speed register, on the single reference clock like all other state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            speed_100 <= psled_pkg::speed_reset;
        end else if (clock_enable) begin
            speed_100 <= next_speed_100;
        end
    end

    // Duplex register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            full_duplex <= psled_pkg::duplex_reset;
        end else if (clock_enable) begin
            full_duplex <= next_full_duplex;
        end
    end

    // Duplex LED: needs a live link as well as full duplex
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            duplex_indicator <= 1'b0;
        end else if (clock_enable) begin
            duplex_indicator <= psled_duplex_on(link_up, full_duplex);
        end
    end

    // Collision LED: half duplex only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            collision_indicator <= 1'b0;
        end else if (clock_enable) begin
            collision_indicator <= psled_collision_on(collision_seen, full_duplex);
        end
    end

    // Good-link LED: same at either speed
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            good_link_indicator <= 1'b0;
        end else if (clock_enable) begin
            good_link_indicator <= link_up;
        end
    end

    // Transmit LED follows transmit activity with one cycle of lag
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            transmit_activity_indicator <= 1'b0;
        end else if (clock_enable) begin
            transmit_activity_indicator <= transmit_active;
        end
    end

    // Receive LED follows receive activity with one cycle of lag
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            receive_activity_indicator <= 1'b0;
        end else if (clock_enable) begin
            receive_activity_indicator <= receive_active;
        end
    end

    // Speed LED and media mode share one source, so they agree after the first enabled edge; in reset the LED is 0 and the mode is 1
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            link_speed_indicator <= 1'b0;
        end else if (clock_enable) begin
            link_speed_indicator <= speed_100;
        end
    end

    // Media signalling mode for the transmit and receive paths
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            media_speed_100 <= psled_pkg::speed_reset;
        end else if (clock_enable) begin
            media_speed_100 <= speed_100;
        end
    end

    // Each shared pin drives only in the LED phase, so resistors never fight it
    for (genvar p = 0; p < psled_pkg::strap_width; p++) begin : g_pin_enable
        always_comb begin
            case (phase)
                psled_pkg::psled_strap_phase: strap_pin_enable[p] = 1'b0;
                psled_pkg::psled_led_phase: strap_pin_enable[p] = 1'b1;
                default: strap_pin_enable[p] = 1'b0;
            endcase
        end
    end

    // Status word: capture flag, link, mode, raw collision and the duplex LED term, upper bits zero
    assign status_word = {
        26'h0,
        strap_captured,
        link_up,
        full_duplex,
        speed_100,
        collision_seen,
        psled_duplex_on(link_up, full_duplex)
    };

    // Read mux: only a read strobe selects a word, otherwise the bus reads zero
    always_comb begin
        next_read_data = 32'h00000000;
        if (reg_read) begin
            case (reg_address)
                psled_pkg::addr_phy_control: next_read_data = {27'h0, phy_control_register};
                psled_pkg::addr_config: next_read_data = config_reg;
                psled_pkg::addr_status: next_read_data = status_word;
                default: next_read_data = 32'h00000000;
            endcase
        end
    end

    // Read data register: the word stands for the one cycle after the strobe
    // Software must take it then; the next cycle shows zero again
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_read_data <= 32'h00000000;
        end else if (clock_enable) begin
            reg_read_data <= next_read_data;
        end
    end
endmodule

// ==== verilog/psled_pkg.sv ====
// Constants shared by the PHY status LED driver
package psled_pkg;
    // Reference clock rate in MHz
    localparam int unsigned clock_mhz = 50;
    // Number of shared strap/LED pins and address width
    localparam int unsigned strap_width = 5;
    // Strap pin positions within the shared bus
    localparam int unsigned pin_duplex = 0;
    localparam int unsigned pin_collision = 1;
    localparam int unsigned pin_good_link = 2;
    localparam int unsigned pin_transmit = 3;
    localparam int unsigned pin_receive = 4;
    // Reset value of the captured PHY address
    localparam logic [4:0] phy_address_reset = 5'h00;
    // Cycles after reset release before the synchronised straps are taken
    localparam logic [1:0] strap_settle_cycles = 2'h2;
    // Mode flops before the first resolve: 100 Mb/s, half duplex
    localparam logic speed_reset = 1'b1;
    localparam logic duplex_reset = 1'b0;
    // Register map of the control/status port (word index = byte address / 4)
    localparam logic [7:0] addr_phy_control = 8'h00;
    localparam logic [7:0] addr_config = 8'h04;
    localparam logic [7:0] addr_status = 8'h08;
    // Field positions in the config register
    localparam int unsigned cfg_force_bit = 0;
    localparam int unsigned cfg_speed_bit = 1;
    localparam int unsigned cfg_duplex_bit = 2;
    localparam logic [31:0] config_reset = 32'h00000003;
    // Media signalling mode
    typedef enum logic [0:0] {
        psled_media_10 = 1'b0,
        psled_media_100 = 1'b1
    } psled_media_t;
    // Output state: drives stay off during reset and the strap read, then LED function
    typedef enum logic [0:0] {
        psled_strap_phase = 1'b0,
        psled_led_phase = 1'b1
    } psled_phase_t;
endpackage
